// File: core/dmbu_pkg.sv
// Purpose: Shared constants and types of the debug mode and breakpoint unit
// Assumes: 32-bit AHB-Lite register words, 4-bit test instruction register
// Notes: Offsets are byte addresses on the register bus
`default_nettype none
package dmbu_pkg;
    // ********************************
    // Register map
    // ********************************
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_RET = 8'h04;
    localparam logic [7:0] ADR_SCR = 8'h08;
    localparam logic [7:0] ADR_IST = 8'h0C;
    localparam logic [7:0] ADR_ICLR = 8'h10;
    localparam logic [7:0] ADR_IEN = 8'h14;
    localparam logic [7:0] ADR_BPCFG = 8'h18;
    localparam int ADR_IB_BASE = 'h40;
    localparam int IB_STRIDE = 'h10;
    localparam int ADR_DB_BASE = 'h80;
    localparam int DB_STRIDE = 'h20;
    localparam int OFS_ADDR = 'h0;
    localparam int OFS_AMASK = 'h4;
    localparam int OFS_BCTRL = 'h8;
    localparam int OFS_VAL = 'hC;
    localparam int OFS_VMASK = 'h10;
    // ********************************
    // Field layout
    // ********************************
    localparam int CTRL_SSTEP_BIT = 0;
    localparam int CTRL_CAUSE_LSB = 1;
    localparam int CTRL_DM_BIT = 30;
    localparam int CTRL_BRK_BIT = 31;
    localparam int CAUSE_W = 4;
    localparam int CAUSE_SS = 0;
    localparam int CAUSE_IB = 1;
    localparam int CAUSE_DB = 2;
    localparam int CAUSE_JT = 3;
    localparam int BPC_EN = 0;
    localparam int BPC_ADDRESS_SPACE_ID_USE = 1;
    localparam int BPC_LOAD = 2;
    localparam int BPC_STORE = 3;
    localparam int BPC_VAL_USE = 4;
    localparam int BPC_ADDRESS_SPACE_ID_LSB = 8;
    localparam int BPC_W = 16;
    localparam int ADDRESS_SPACE_ID_W = 8;
    localparam int EV_ENTER = 0;
    localparam int EV_EXIT = 1;
    localparam int EV_JTAG = 2;
    localparam int EV_W = 3;
    localparam int MAX_IB = 4;
    localparam int MAX_DB = 2;
    // ********************************
    // Test access port
    // ********************************
    localparam int IR_W = 4;
    localparam logic [3:0] IR_IDCODE = 4'h1;
    localparam logic [3:0] IR_CTRL = 4'h8;
    localparam logic [3:0] IR_RET = 4'h9;
    localparam logic [3:0] IR_SCR = 4'hA;
    localparam logic [3:0] IR_BYPASS = 4'hF;
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008, TAP_SHIFT_DR = 16'h0010, TAP_EXIT1_DR = 16'h0020,
        TAP_PAUSE_DR = 16'h0040, TAP_EXIT2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SHIFT_IR = 16'h0800,
        TAP_EXIT1_IR = 16'h1000, TAP_PAUSE_IR = 16'h2000, TAP_EXIT2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } dmbu_tap_t;
endpackage : dmbu_pkg
`default_nettype wire

// File: core/dmbu_unit.sv
// Purpose: Debug mode, debug registers, breakpoints and test access port
// Assumes: Core strobes are on sys_clk; tck, tms and tdi are asynchronous pins
// Notes: Rules listed below
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dmbu_unit #(
    parameter int BP_OPTION = 2,
    parameter logic [31:0] IDCODE_VAL = 32'h0000_0001
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // Core fetch and load/store
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_addr,
    input wire logic [dmbu_pkg::ADDRESS_SPACE_ID_W-1:0] address_space_id,
    input wire logic ls_valid,
    input wire logic ls_store,
    input wire logic [31:0] ls_addr,
    input wire logic [31:0] ls_value,
    input wire logic [31:0] ls_pc,
    input wire logic instr_retire,
    input wire logic [31:0] next_pc,
    input wire logic debug_return_instr,
    // Core control
    output logic debug_exc,
    output logic debug_mode_out,
    output logic pc_load,
    output logic [31:0] resume_pc,
    // Test access port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    // Interrupt
    output logic irq
);
    import dmbu_pkg::*;

    // ********************************
    // Build option
    // ********************************
    // breakpoint count choice
    localparam int NUM_IB = (BP_OPTION == 2) ? 4 : ((BP_OPTION == 1) ? 2 : 0);
    localparam int NUM_DB = (BP_OPTION == 2) ? 2 : ((BP_OPTION == 1) ? 1 : 0);

    // ********************************
    // State
    // ********************************
    typedef struct packed {
        logic tck_s1;
        logic tck_s2;
        logic tck_d;
        logic tms_s1;
        logic tms_s2;
        logic tdi_s1;
        logic tdi_s2;
        dmbu_tap_t tap;
        logic [IR_W-1:0] ir;
        logic [IR_W-1:0] ir_sh;
        logic [31:0] dr_sh;
        logic tdo;
        logic tdo_drv;
        logic dm;
        logic sstep;
        logic [CAUSE_W-1:0] cause;
        logic [31:0] ret_addr;
        logic [31:0] scratch;
        logic [EV_W-1:0] ist;
        logic [EV_W-1:0] ien;
        logic [MAX_IB-1:0][31:0] ib_addr;
        logic [MAX_IB-1:0][31:0] ib_mask;
        logic [MAX_IB-1:0][BPC_W-1:0] ib_ctrl;
        logic [MAX_DB-1:0][31:0] db_addr;
        logic [MAX_DB-1:0][31:0] db_amask;
        logic [MAX_DB-1:0][31:0] db_val;
        logic [MAX_DB-1:0][31:0] db_vmask;
        logic [MAX_DB-1:0][BPC_W-1:0] db_ctrl;
        logic exc;
        logic pc_load;
        logic [31:0] resume_pc;
        logic dph;
        logic dph_wr;
        logic rd_done;
        logic [7:0] dph_addr;
        logic [31:0] hrdata;
    } dmbu_state_t;

    dmbu_state_t st_r;
    dmbu_state_t st_nxt;

    // ********************************
    // Functions
    // ********************************
    // masked bits ignored
    function automatic logic masked_eq(logic [31:0] a, logic [31:0] b, logic [31:0] m);
        masked_eq = ((a ^ b) & ~m) == 32'h0000_0000;
    endfunction : masked_eq

    function automatic logic [7:0] bp_adr(int base, int stride, int idx, int ofs);
        bp_adr = 8'(base + stride * idx + ofs);
    endfunction : bp_adr

    function automatic logic [31:0] ctrl_word(dmbu_state_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[CTRL_SSTEP_BIT] = s.sstep;
        v[CTRL_CAUSE_LSB +: CAUSE_W] = s.cause;
        v[CTRL_DM_BIT] = s.dm;
        ctrl_word = v;
    endfunction : ctrl_word

    function automatic logic address_space_id_ok(logic [BPC_W-1:0] c, logic [ADDRESS_SPACE_ID_W-1:0] id);
        address_space_id_ok = !c[BPC_ADDRESS_SPACE_ID_USE] || (c[BPC_ADDRESS_SPACE_ID_LSB +: ADDRESS_SPACE_ID_W] == id);
    endfunction : address_space_id_ok

    function automatic logic [31:0] rd_word(dmbu_state_t s, logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == ADR_CTRL) begin
            v = ctrl_word(s);
        end else if (a == ADR_RET) begin
            v = s.ret_addr;
        end else if (a == ADR_SCR) begin
            v = s.scratch;
        end else if (a == ADR_IST) begin
            v[EV_W-1:0] = s.ist;
        end else if (a == ADR_IEN) begin
            v[EV_W-1:0] = s.ien;
        end else if (a == ADR_BPCFG) begin
            v[3:0] = 4'(NUM_IB);
            v[7:4] = 4'(NUM_DB);
        end
        for (int i = 0; i < NUM_IB; i++) begin
            if (a == bp_adr(ADR_IB_BASE, IB_STRIDE, i, OFS_ADDR)) begin
                v = s.ib_addr[i];
            end
            if (a == bp_adr(ADR_IB_BASE, IB_STRIDE, i, OFS_AMASK)) begin
                v = s.ib_mask[i];
            end
            if (a == bp_adr(ADR_IB_BASE, IB_STRIDE, i, OFS_BCTRL)) begin
                v = {16'h0000, s.ib_ctrl[i]};
            end
        end
        for (int i = 0; i < NUM_DB; i++) begin
            if (a == bp_adr(ADR_DB_BASE, DB_STRIDE, i, OFS_ADDR)) begin
                v = s.db_addr[i];
            end
            if (a == bp_adr(ADR_DB_BASE, DB_STRIDE, i, OFS_AMASK)) begin
                v = s.db_amask[i];
            end
            if (a == bp_adr(ADR_DB_BASE, DB_STRIDE, i, OFS_BCTRL)) begin
                v = {16'h0000, s.db_ctrl[i]};
            end
            if (a == bp_adr(ADR_DB_BASE, DB_STRIDE, i, OFS_VAL)) begin
                v = s.db_val[i];
            end
            if (a == bp_adr(ADR_DB_BASE, DB_STRIDE, i, OFS_VMASK)) begin
                v = s.db_vmask[i];
            end
        end
        rd_word = v;
    endfunction : rd_word

    function automatic dmbu_tap_t tap_next(dmbu_tap_t t, logic m);
        unique case (t)
            TAP_RESET: tap_next = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_next = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_next = TAP_RESET;
        endcase
    endfunction : tap_next

    // ********************************
    // Next state
    // ********************************
    always_comb begin
        logic rise;
        logic fall;
        logic brk_req;
        logic ib_hit;
        logic db_hit;
        logic ss_hit;
        logic [EV_W-1:0] ev;
        logic [EV_W-1:0] clr;
        logic [31:0] w;
        logic [7:0] a;
        rise = 1'b0;
        fall = 1'b0;
        brk_req = 1'b0;
        ib_hit = 1'b0;
        db_hit = 1'b0;
        ss_hit = 1'b0;
        ev = '0;
        clr = '0;
        w = hwdata;
        a = st_r.dph_addr;
        st_nxt = st_r;
        st_nxt.exc = 1'b0;
        st_nxt.pc_load = 1'b0;
        // Pin synchronisers
        st_nxt.tck_s1 = tck;
        st_nxt.tck_s2 = st_r.tck_s1;
        st_nxt.tck_d = st_r.tck_s2;
        st_nxt.tms_s1 = tms;
        st_nxt.tms_s2 = st_r.tms_s1;
        st_nxt.tdi_s1 = tdi;
        st_nxt.tdi_s2 = st_r.tdi_s1;
        rise = st_r.tck_s2 && !st_r.tck_d;
        fall = !st_r.tck_s2 && st_r.tck_d;
        if (rise) begin
            st_nxt.tap = tap_next(st_r.tap, st_r.tms_s2);
            unique case (st_r.tap)
                TAP_RESET: st_nxt.ir = IR_IDCODE;
                TAP_CAP_IR: st_nxt.ir_sh = IR_CAPTURE;
                TAP_SHIFT_IR: st_nxt.ir_sh = {st_r.tdi_s2, st_r.ir_sh[IR_W-1:1]};
                TAP_UPD_IR: st_nxt.ir = st_r.ir_sh;
                TAP_CAP_DR: begin
                    unique case (st_r.ir)
                        IR_IDCODE: st_nxt.dr_sh = IDCODE_VAL;
                        IR_CTRL: st_nxt.dr_sh = ctrl_word(st_r);
                        IR_RET: st_nxt.dr_sh = st_r.ret_addr;
                        IR_SCR: st_nxt.dr_sh = st_r.scratch;
                        default: st_nxt.dr_sh = 32'h0000_0000;
                    endcase
                end
                TAP_SHIFT_DR: begin
                    if (st_r.ir == IR_IDCODE || st_r.ir == IR_CTRL ||
                        st_r.ir == IR_RET || st_r.ir == IR_SCR) begin
                        st_nxt.dr_sh = {st_r.tdi_s2, st_r.dr_sh[31:1]};
                    end else begin
                        st_nxt.dr_sh = {31'h0000_0000, st_r.tdi_s2};
                    end
                end
                TAP_UPD_DR: begin
                    if (st_r.ir == IR_CTRL) begin
                        st_nxt.sstep = st_r.dr_sh[CTRL_SSTEP_BIT];
                        brk_req = st_r.dr_sh[CTRL_BRK_BIT];
                        ev[EV_JTAG] = 1'b1;
                    end else if (st_r.ir == IR_RET) begin
                        st_nxt.ret_addr = st_r.dr_sh;
                        ev[EV_JTAG] = 1'b1;
                    end else if (st_r.ir == IR_SCR) begin
                        st_nxt.scratch = st_r.dr_sh;
                        ev[EV_JTAG] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        if (fall) begin
            st_nxt.tdo = (st_r.tap == TAP_SHIFT_IR) ? st_r.ir_sh[0] : st_r.dr_sh[0];
            st_nxt.tdo_drv = (st_r.tap == TAP_SHIFT_IR) || (st_r.tap == TAP_SHIFT_DR);
        end
        // Bus data phase
        if (st_r.dph && st_r.dph_wr) begin
            if (a == ADR_CTRL) begin
                st_nxt.sstep = w[CTRL_SSTEP_BIT];
                brk_req = brk_req || w[CTRL_BRK_BIT];
            end else if (a == ADR_RET) begin
                st_nxt.ret_addr = w;
            end else if (a == ADR_SCR) begin
                st_nxt.scratch = w;
            end else if (a == ADR_ICLR) begin
                clr = w[EV_W-1:0];
            end else if (a == ADR_IEN) begin
                st_nxt.ien = w[EV_W-1:0];
            end
            for (int i = 0; i < NUM_IB; i++) begin
                if (a == bp_adr(ADR_IB_BASE, IB_STRIDE, i, OFS_ADDR)) begin
                    st_nxt.ib_addr[i] = w;
                end
                if (a == bp_adr(ADR_IB_BASE, IB_STRIDE, i, OFS_AMASK)) begin
                    st_nxt.ib_mask[i] = w;
                end
                if (a == bp_adr(ADR_IB_BASE, IB_STRIDE, i, OFS_BCTRL)) begin
                    st_nxt.ib_ctrl[i] = w[BPC_W-1:0];
                end
            end
            for (int i = 0; i < NUM_DB; i++) begin
                if (a == bp_adr(ADR_DB_BASE, DB_STRIDE, i, OFS_ADDR)) begin
                    st_nxt.db_addr[i] = w;
                end
                if (a == bp_adr(ADR_DB_BASE, DB_STRIDE, i, OFS_AMASK)) begin
                    st_nxt.db_amask[i] = w;
                end
                if (a == bp_adr(ADR_DB_BASE, DB_STRIDE, i, OFS_BCTRL)) begin
                    st_nxt.db_ctrl[i] = w[BPC_W-1:0];
                end
                if (a == bp_adr(ADR_DB_BASE, DB_STRIDE, i, OFS_VAL)) begin
                    st_nxt.db_val[i] = w;
                end
                if (a == bp_adr(ADR_DB_BASE, DB_STRIDE, i, OFS_VMASK)) begin
                    st_nxt.db_vmask[i] = w;
                end
            end
        end
        if (st_r.dph && !st_r.dph_wr && !st_r.rd_done) begin
            st_nxt.hrdata = rd_word(st_r, a);
            st_nxt.rd_done = 1'b1;
        end
        if (hready) begin
            st_nxt.dph = hsel && htrans[1];
            st_nxt.dph_wr = hwrite;
            st_nxt.dph_addr = {haddr[7:2], 2'b00};
            st_nxt.rd_done = 1'b0;
        end
        // Breakpoint compare
        for (int i = 0; i < NUM_IB; i++) begin
            if (fetch_valid && st_r.ib_ctrl[i][BPC_EN] &&
                masked_eq(fetch_addr, st_r.ib_addr[i], st_r.ib_mask[i]) &&
                address_space_id_ok(st_r.ib_ctrl[i], address_space_id)) begin
                ib_hit = 1'b1;
            end
        end
        for (int i = 0; i < NUM_DB; i++) begin
            if (ls_valid && st_r.db_ctrl[i][BPC_EN] &&
                (ls_store ? st_r.db_ctrl[i][BPC_STORE] : st_r.db_ctrl[i][BPC_LOAD]) &&
                masked_eq(ls_addr, st_r.db_addr[i], st_r.db_amask[i]) &&
                address_space_id_ok(st_r.db_ctrl[i], address_space_id) &&
                (!st_r.db_ctrl[i][BPC_VAL_USE] ||
                 masked_eq(ls_value, st_r.db_val[i], st_r.db_vmask[i]))) begin
                db_hit = 1'b1;
            end
        end
        ss_hit = st_r.sstep && instr_retire;
        // Debug mode entry and exit
        if (st_r.dm) begin
            if (debug_return_instr) begin
                st_nxt.dm = 1'b0;
                st_nxt.pc_load = 1'b1;
                st_nxt.resume_pc = st_r.ret_addr;
                ev[EV_EXIT] = 1'b1;
            end
        end else if (ib_hit || db_hit || ss_hit || brk_req) begin
            st_nxt.dm = 1'b1;
            st_nxt.exc = 1'b1;
            st_nxt.cause = '0;
            st_nxt.cause[CAUSE_SS] = ss_hit;
            st_nxt.cause[CAUSE_IB] = ib_hit;
            st_nxt.cause[CAUSE_DB] = db_hit;
            st_nxt.cause[CAUSE_JT] = brk_req;
            if (ib_hit) begin
                st_nxt.ret_addr = fetch_addr;
            end else if (db_hit) begin
                st_nxt.ret_addr = ls_pc;
            end else begin
                st_nxt.ret_addr = next_pc;
            end
            ev[EV_ENTER] = 1'b1;
        end
        // Sticky events, set beats clear
        st_nxt.ist = (st_r.ist & ~clr) | ev;
    end

    // ********************************
    // Registers
    // ********************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.tap <= TAP_RESET;
            st_r.ir <= IR_IDCODE;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************
    // Outputs
    // ********************************
    assign hreadyout = !(st_r.dph && !st_r.dph_wr && !st_r.rd_done);
    assign hresp = 1'b0;
    assign hrdata = st_r.hrdata;
    assign debug_exc = st_r.exc;
    assign debug_mode_out = st_r.dm;
    assign pc_load = st_r.pc_load;
    assign resume_pc = st_r.resume_pc;
    assign tdo = st_r.tdo;
    assign tdo_oe_n = !st_r.tdo_drv;
    assign irq = |(st_r.ist & st_r.ien);
endmodule : dmbu_unit
`default_nettype wire

// File: dv/dmbu_probe.sv
// Purpose: Probe model driving the serial test port
// Assumes: Test clock period 400 ns, held low between scans
// Notes: Each scan resets the port, loads IR, then shifts 32 DR bits
`timescale 1ns/1ps
`default_nettype none
module dmbu_probe (
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    // ********************************
    // Bit and scan tasks
    // ********************************
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    task step(input logic m, input logic d, output logic o);
        tms = m;
        tdi = d;
        #200 tck = 1'b1;
        o = tdo;
        #200 tck = 1'b0;
    endtask : step
    task scan(input logic [3:0] ir, input logic [31:0] din, output logic [31:0] dout);
        logic o;
        logic [9:0] pre;
        pre = 10'h3EC;
        for (int i = 9; i >= 0; i--) step(pre[i], 1'b0, o);
        for (int i = 0; i < 4; i++) step(i == 3, ir[i], o);
        for (int i = 3; i >= 0; i--) step(i > 1, 1'b0, o);
        for (int i = 0; i < 32; i++) step(i == 31, din[i], dout[i]);
        step(1'b1, 1'b0, o);
        step(1'b0, 1'b0, o);
        tdi = ~tdi;
    endtask : scan
endmodule : dmbu_probe
`default_nettype wire

// File: dv/dmbu_unit_sva.sv
// Purpose: Port checker of the debug mode and breakpoint unit
// Assumes: One clock domain, async low reset
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module dmbu_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Bus
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    // Core
    input wire logic debug_return_instr,
    input wire logic debug_exc,
    input wire logic debug_mode_out,
    input wire logic pc_load,
    input wire logic [31:0] resume_pc
);
    // ********************************
    // Properties
    // ********************************
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd_req;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence s_rd_ans;
        !hreadyout ##1 hreadyout;
    endsequence
    chk_read_wait: assert property (s_rd_req |=> s_rd_ans)
        else $error("read wait wrong");
    chk_enter_mode: assert property (debug_exc |-> debug_mode_out)
        else $error("exception without debug mode");
    chk_no_reenter: assert property (debug_mode_out |=> !debug_exc)
        else $error("exception inside debug mode");
    chk_exc_single: assert property (debug_exc |=> !debug_exc)
        else $error("exception pulse too long");
    chk_rise_cause: assert property ($rose(debug_mode_out) |-> debug_exc)
        else $error("debug mode without exception");
    chk_return_exit: assert property (debug_mode_out && debug_return_instr |=> !debug_mode_out && pc_load)
        else $error("return did not exit");
    chk_return_ignore: assert property (!debug_mode_out |=> !pc_load)
        else $error("load outside debug mode");
    chk_exit_load: assert property ($fell(debug_mode_out) |-> pc_load)
        else $error("exit without load");
    chk_resume_hold: assert property (!pc_load |-> $stable(resume_pc))
        else $error("resume address moved");
endmodule : dmbu_sva
`default_nettype wire

// File: dv/tb_debug_mode_breakpoint_unit.sv
// Purpose: Self-checking bench of the debug mode and breakpoint unit
// Assumes: 50 ns clock, probe model on the test port
// Notes: One task per scenario
`timescale 1ns/1ps
`default_nettype none
module tb_debug_mode_breakpoint_unit;
    import dmbu_pkg::*;
    localparam logic [31:0] ID = 32'h0000_0A5B; // Arbitrary code
    logic sys_clk, rst_n, hwrite, fetch_valid, ls_valid, ls_store, instr_retire;
    logic debug_return_instr, hreadyout, hresp, debug_exc, debug_mode_out, pc_load;
    logic tck, tms, tdi, tdo, tdo_oe_n, irq;
    logic [1:0] htrans;
    logic [7:0] address_space_id;
    logic [31:0] haddr, hwdata, hrdata, fetch_addr, ls_addr, ls_value, ls_pc, next_pc;
    logic [31:0] resume_pc, q;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    dmbu_unit #(.BP_OPTION(2), .IDCODE_VAL(ID)) i_dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fetch_valid(fetch_valid),
        .fetch_addr(fetch_addr), .address_space_id(address_space_id), .ls_valid(ls_valid),
        .ls_store(ls_store), .ls_addr(ls_addr), .ls_value(ls_value), .ls_pc(ls_pc),
        .instr_retire(instr_retire), .next_pc(next_pc),
        .debug_return_instr(debug_return_instr), .debug_exc(debug_exc),
        .debug_mode_out(debug_mode_out), .pc_load(pc_load), .resume_pc(resume_pc),
        .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .irq(irq)
    );
    dmbu_probe i_probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    // ********************************
    // Shared tasks
    // ********************************
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask : chk
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : ahb
    task wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input string n);
        ahb(1'b0, a, 32'h0);
        chk(n, e, q);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : rd
    task core(input int k, input logic [31:0] a, input logic [31:0] v, input logic e);
        fetch_valid <= (k == 0);
        ls_valid <= (k == 1 || k == 2);
        ls_store <= (k == 2);
        instr_retire <= (k == 3);
        debug_return_instr <= (k == 4);
        {fetch_addr, ls_addr, next_pc, ls_value, ls_pc} <= {a, a, a, v, ~a};
        @(posedge sys_clk);
        {fetch_valid, ls_valid, instr_retire, debug_return_instr} <= 4'h0;
        @(negedge sys_clk);
        chk("exc_or_load", {31'h0, e}, {31'h0, (k == 4) ? pc_load : debug_exc});
        @(posedge sys_clk);
    endtask : core
    task irq_is(input logic e);
        repeat (2) @(negedge sys_clk);
        chk("irq", {31'h0, e}, {31'h0, irq});
        @(posedge sys_clk);
    endtask : irq_is
    // ********************************
    // Scenarios
    // ********************************
    task t_regs();
        rd(ADR_CTRL, 32'h0, "ctrl");
        rd(ADR_BPCFG, 32'h0000_0024, "cfg");
        rd(8'hC0, 32'h0, "no_bp");
        wr(ADR_SCR, 32'h1234_5678);
        rd(ADR_SCR, 32'h1234_5678, "scr");
        $display("regs done");
    endtask : t_regs
    task t_ibp();
        wr(8'h40, 32'h0000_1000);
        wr(8'h44, 32'h0000_000F);
        wr(8'h48, 32'h0000_0503);
        address_space_id <= 8'h06;
        core(0, 32'h0000_100C, 32'h0, 1'b0);
        address_space_id <= 8'h05;
        core(0, 32'h0000_1010, 32'h0, 1'b0);
        core(0, 32'h0000_100C, 32'h0, 1'b1);
        core(0, 32'h0000_1000, 32'h0, 1'b0);
        rd(ADR_CTRL, 32'h4000_0004, "ctrl");
        rd(ADR_RET, 32'h0000_100C, "ret");
        chk("dm_out", 32'h1, {31'h0, debug_mode_out});
        core(4, 32'h0, 32'h0, 1'b1);
        chk("resume", 32'h0000_100C, resume_pc);
        $display("ibp done");
    endtask : t_ibp
    task t_dbp();
        wr(8'h80, 32'h0000_2000);
        wr(8'h84, 32'h0);
        wr(8'h88, 32'h0000_0019);
        wr(8'h8C, 32'h55AA_0000);
        wr(8'h90, 32'h0000_FFFF);
        core(1, 32'h0000_2000, 32'h55AA_1234, 1'b0);
        core(2, 32'h0000_2000, 32'h55AB_1234, 1'b0);
        core(2, 32'h0000_2004, 32'h55AA_1234, 1'b0);
        core(2, 32'h0000_2000, 32'h55AA_9999, 1'b1);
        rd(ADR_RET, 32'hFFFF_DFFF, "ret");
        core(4, 32'h0, 32'h0, 1'b1);
        $display("dbp done");
    endtask : t_dbp
    task t_irq();
        wr(ADR_IEN, 32'h0000_0002);
        irq_is(1'b1);
        wr(ADR_IEN, 32'h0);
        irq_is(1'b0);
        wr(ADR_ICLR, 32'h0000_0007);
        rd(ADR_IST, 32'h0, "ist");
        $display("irq done");
    endtask : t_irq
    task t_jtag();
        i_probe.scan(IR_SCR, 32'hCAFE_0001, q);
        chk("scr_tap", 32'h1234_5678, q);
        chk("oe_n", 32'h1, {31'h0, tdo_oe_n});
        i_probe.scan(IR_IDCODE, 32'h0, q);
        chk("id", ID, q);
        i_probe.scan(IR_CTRL, 32'h0000_0001, q);
        @(posedge sys_clk);
        rd(ADR_SCR, 32'hCAFE_0001, "scr");
        core(3, 32'h0000_3000, 32'h0, 1'b1);
        rd(ADR_RET, 32'h0000_3000, "ret");
        rd(ADR_IST, 32'h0000_0005, "ist");
        core(4, 32'h0, 32'h0, 1'b1);
        $display("jtag done");
    endtask : t_jtag
    task finish_test();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        rst_n = 1'b0;
        {hwrite, fetch_valid, ls_valid, ls_store, instr_retire, debug_return_instr} = 6'h0;
        htrans = 2'h0;
        address_space_id = 8'h0;
        {haddr, hwdata, fetch_addr, ls_addr, ls_value, ls_pc, next_pc} = 224'h0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_ibp();
        t_dbp();
        t_irq();
        t_jtag();
        finish_test();
    end
endmodule : tb_debug_mode_breakpoint_unit
bind dmbu_unit dmbu_sva i_sva (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .debug_return_instr(debug_return_instr),
    .debug_exc(debug_exc), .debug_mode_out(debug_mode_out), .pc_load(pc_load),
    .resume_pc(resume_pc)
);
`default_nettype wire
